// file: cmss_pkg.sv
// cmss_pkg: constants, register map and types of the mode/serial block
// assumes a 125 MHz pclk and an apb slave with 32-bit data
// Functional notes
// [R1] upper selector position runs the program
// [R2] centre position obeys tool start/stop commands
// [R3] entering centre position keeps current mode
// [R4] lower position is program mode, no execution
// [R5] test only with switch in test position; the arm is held until centre, so run from init can still enter test
// [R6] baud switch forces tool port to 9600
// [R7] source switch picks internal ram or rom
// [R8] lock switch blocks writes; fourth switch unused
// [R9] switches sampled once after power-up only
// [R10] request-to-send and equipment-ready always asserted
// [R11] general transmit waits for clear-to-send
// [R12] serial baud and format come from registers
// [R13] default 19200, 8 bits, odd, 1 stop, link
// [R14] general mode needs serial config register changed
// [R15] link/general mode switchable at run time
// [R16] lamp selector shows first or second 32 inputs
// [R17] connector a is X0-X1F, b X20-X3F
// [R18] run from armed program mode starts test
// [R19] bit timing divided from clock, reset default
package cmss_pkg;

    localparam int CLK_HZ     = 125_000_000;
    localparam int BAUD_9600  = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    localparam int BAUD_57600 = 57600;
    localparam int BAUD_115K  = 115200;
    localparam int DIV_W      = 16;

    localparam logic [DIV_W-1:0] DIV_9600  = DIV_W'(CLK_HZ / BAUD_9600);
    localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(CLK_HZ / BAUD_19200);
    localparam logic [DIV_W-1:0] DIV_38400 = DIV_W'(CLK_HZ / BAUD_38400);
    localparam logic [DIV_W-1:0] DIV_57600 = DIV_W'(CLK_HZ / BAUD_57600);
    localparam logic [DIV_W-1:0] DIV_115K  = DIV_W'(CLK_HZ / BAUD_115K);

    // baud codes held in the configuration registers
    localparam logic [2:0] BAUD_C_9600  = 3'h0;
    localparam logic [2:0] BAUD_C_19200 = 3'h1;
    localparam logic [2:0] BAUD_C_38400 = 3'h2;
    localparam logic [2:0] BAUD_C_57600 = 3'h3;
    localparam logic [2:0] BAUD_C_115K  = 3'h4;

    // register byte offsets
    localparam logic [7:0] OFF_CMD  = 8'h00;
    localparam logic [7:0] OFF_SER  = 8'h04;
    localparam logic [7:0] OFF_TOOL = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_TXD  = 8'h10;
    localparam logic [7:0] OFF_INA  = 8'h14;
    localparam logic [7:0] OFF_INB  = 8'h18;

    localparam int CMD_RUN_BIT  = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int SW_BAUD      = 0;
    localparam int SW_SRC       = 1;
    localparam int SW_LOCK      = 2;

    // selector and initialise/test switch encodings
    localparam logic [1:0] SEL_RUN    = 2'h0;
    localparam logic [1:0] SEL_REMOTE = 2'h1;
    localparam logic [1:0] SEL_PROGRAM_MODE   = 2'h2;
    localparam logic [1:0] ITS_CENTER = 2'h0;
    localparam logic [1:0] ITS_INIT   = 2'h1;
    localparam logic [1:0] ITS_TEST   = 2'h2;

    localparam int FRAME_W = 12;

    typedef enum logic [1:0] {MODE_PROGRAM_MODE, MODE_RUN, MODE_TEST} cmss_mode_e;

    typedef struct packed {
        logic       gp_mode;
        logic       two_stop;
        logic       par_even;
        logic       par_en;
        logic       seven;
        logic [2:0] baud;
    } cmss_ser_cfg_s;

    localparam cmss_ser_cfg_s SER_RST = '{gp_mode: 1'b0, two_stop: 1'b0,
        par_even: 1'b0, par_en: 1'b1, seven: 1'b0, baud: BAUD_C_19200};
    localparam logic [2:0] TOOL_RST = BAUD_C_19200;

    typedef struct packed {
        logic [19:0] zero;
        logic        gp_mode;
        logic        tx_busy;
        logic        buf_full;
        logic        cts;
        logic [3:0]  sw;
        logic        sampled;
        logic        test_arm;
        logic [1:0]  mode;
    } cmss_stat_s;

    function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] code);
        logic [DIV_W-1:0] d;
        d = DIV_19200;
        case (code)
            BAUD_C_9600:  d = DIV_9600;
            BAUD_C_38400: d = DIV_38400;
            BAUD_C_57600: d = DIV_57600;
            BAUD_C_115K:  d = DIV_115K;
            default:      d = DIV_19200;
        endcase
        return d;
    endfunction : baud_div

endpackage : cmss_pkg

// file: cmss_mode_serial.sv
// cmss_mode_serial: operating mode, power-up switches, serial port
// setup and transmit, input lamp paging by the lamp_page_sel pin, registers behind an apb slave
// assumes switches and pins already synchronous to pclk
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module cmss_mode_serial #(
    parameter int IN_W = 32
) (
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // front panel
    input  wire logic [1:0]          mode_sel,
    input  wire logic [1:0]          init_test_sw,
    input  wire logic [3:0]          cfg_sw,
    input  wire logic                lamp_page_sel,
    // input connectors
    input  wire logic [IN_W-1:0]     input_connector_a,
    input  wire logic [IN_W-1:0]     input_connector_b,
    // serial port
    input  wire logic                cts,
    output logic                     txd,
    output logic                     rts,
    output logic                     er,
    // cpu status
    output logic                     run_exec,
    output logic                     program_mode,
    output logic                     test_mode,
    output logic                     mem_init,
    output logic                     program_mode_src_rom,
    output logic                     program_mode_write_en,
    output logic [15:0]              tool_baud_div,
    output logic [IN_W-1:0]          lamp
);

    // apb decode
    logic                    pready_q;
    logic                    pslverr_q;
    logic [31:0]             prdata_q;
    logic [31:0]             rd_val;
    wire acc     = psel && penable;
    wire done    = acc && pready_q;
    wire wr_en   = done && pwrite;
    wire hit_cmd = (paddr == cmss_pkg::OFF_CMD);
    wire hit_ser = (paddr == cmss_pkg::OFF_SER);
    wire hit_tl  = (paddr == cmss_pkg::OFF_TOOL);
    wire hit_st  = (paddr == cmss_pkg::OFF_STAT);
    wire hit_txd = (paddr == cmss_pkg::OFF_TXD);
    wire hit_ina = (paddr == cmss_pkg::OFF_INA);
    wire hit_inb = (paddr == cmss_pkg::OFF_INB);
    wire mapped  = hit_cmd || hit_ser || hit_tl || hit_st
                || hit_txd || hit_ina || hit_inb;

    // state declared ahead of the read mux
    cmss_pkg::cmss_mode_e    st_q;
    cmss_pkg::cmss_mode_e    st_d;
    cmss_pkg::cmss_ser_cfg_s ser_q;
    cmss_pkg::cmss_stat_s    stat;
    logic [2:0]              tool_code_q;
    logic                    sampled_q;
    logic [3:0]              sw_q;
    logic                    test_arm_q;
    logic                    busy_q;
    logic [7:0]              buf_mem [2];
    logic                    wp_q;
    logic                    rp_q;
    logic [1:0]              cnt_q;

    wire buf_full  = cnt_q[1];
    wire buf_valid = (cnt_q != 2'h0);

    // a write to a full buffer is held in the access phase
    wire tx_stall = pwrite && hit_txd && buf_full;
    wire ans      = acc && !pready_q && !tx_stall;

    assign stat = '{zero: 20'h0, gp_mode: ser_q.gp_mode,
        tx_busy: busy_q, buf_full: buf_full, cts: cts, sw: sw_q,
        sampled: sampled_q, test_arm: test_arm_q, mode: st_q};

    // [R17] input address map
    assign rd_val = hit_ser ? {24'h0, ser_q}
                  : hit_tl  ? {29'h0, tool_code_q}
                  : hit_st  ? stat
                  : hit_ina ? 32'(input_connector_a)
                  : hit_inb ? 32'(input_connector_b)
                  : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= ans;
            pslverr_q <= ans && !mapped;
            prdata_q  <= (ans && !pwrite) ? rd_val : 32'h0;
        end
    end

    // [R2] tool start/stop commands
    wire cmd_run  = wr_en && hit_cmd && pwdata[cmss_pkg::CMD_RUN_BIT];
    wire cmd_stop = wr_en && hit_cmd && pwdata[cmss_pkg::CMD_STOP_BIT];

    // [R9] one-shot switch capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sampled_q <= 1'b0;
            sw_q      <= 4'h0;
        end else if (!sampled_q) begin
            sampled_q <= 1'b1;
            sw_q      <= cfg_sw;
        end
    end

    // mode machine
    wire sel_run  = (mode_sel == cmss_pkg::SEL_RUN);
    wire sel_rem  = (mode_sel == cmss_pkg::SEL_REMOTE);
    wire sel_program_mode = (mode_sel == cmss_pkg::SEL_PROGRAM_MODE);
    wire its_test = (init_test_sw == cmss_pkg::ITS_TEST);
    wire its_init = (init_test_sw == cmss_pkg::ITS_INIT);
    wire its_ctr  = (init_test_sw == cmss_pkg::ITS_CENTER);
    wire go       = sel_run || (sel_rem && cmd_run);
    wire halt     = sel_program_mode || (sel_rem && cmd_stop);

    always_comb begin
        st_d = st_q;
        case (st_q)
            cmss_pkg::MODE_PROGRAM_MODE: begin
                // [R1] run selector starts
                // [R18] armed test start
                if (go) begin
                    st_d = test_arm_q ? cmss_pkg::MODE_TEST
                                      : cmss_pkg::MODE_RUN;
                end
            end
            cmss_pkg::MODE_RUN,
            cmss_pkg::MODE_TEST: begin
                // [R4] program position stops
                // [R3] centre keeps mode
                if (halt) begin
                    st_d = cmss_pkg::MODE_PROGRAM_MODE;
                end
            end
            default: st_d = cmss_pkg::MODE_PROGRAM_MODE;
        endcase
    end

    logic init_prev_q;
    logic mem_init_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q        <= cmss_pkg::MODE_PROGRAM_MODE;
            test_arm_q  <= 1'b0;
            init_prev_q <= 1'b0;
            mem_init_q  <= 1'b0;
        end else begin
            st_q        <= st_d;
            init_prev_q <= its_init;
            // [R5] arm only from test position
            if (st_q == cmss_pkg::MODE_PROGRAM_MODE && its_test) begin
                test_arm_q <= 1'b1;
            end else if (st_q == cmss_pkg::MODE_PROGRAM_MODE && its_ctr) begin
                test_arm_q <= 1'b0;
            end
            // [R4] memory init in program mode
            mem_init_q <= (st_q == cmss_pkg::MODE_PROGRAM_MODE)
                          && its_init && !init_prev_q;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // [R13] default serial format
            ser_q       <= cmss_pkg::SER_RST;
            tool_code_q <= cmss_pkg::TOOL_RST;
        end else begin
            // [R14] general mode via config
            // [R15] runtime mode switch
            if (wr_en && hit_ser) begin
                ser_q <= cmss_pkg::cmss_ser_cfg_s'(pwdata[7:0]);
            end
            if (wr_en && hit_tl) begin
                tool_code_q <= pwdata[2:0];
            end
        end
    end

    // panel-derived outputs
    logic [15:0]     tool_div_q;
    logic [IN_W-1:0] lamp_q;
    logic            run_q;
    logic            program_mode_q;
    logic            test_q;
    logic            src_q;
    logic            wen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tool_div_q <= cmss_pkg::DIV_19200;
            lamp_q     <= '0;
            run_q      <= 1'b0;
            program_mode_q     <= 1'b1;
            test_q     <= 1'b0;
            src_q      <= 1'b0;
            wen_q      <= 1'b1;
        end else begin
            // [R6] forced tool baud
            tool_div_q <= sw_q[cmss_pkg::SW_BAUD] ? cmss_pkg::DIV_9600
                        : cmss_pkg::baud_div(tool_code_q);
            // [R16] lamp page select
            lamp_q <= lamp_page_sel ? input_connector_b
                                    : input_connector_a;
            run_q  <= (st_q != cmss_pkg::MODE_PROGRAM_MODE);
            program_mode_q <= (st_q == cmss_pkg::MODE_PROGRAM_MODE);
            test_q <= (st_q == cmss_pkg::MODE_TEST) || test_arm_q;
            // [R7] program source switch
            src_q  <= sw_q[cmss_pkg::SW_SRC];
            // [R8] write lock switch
            wen_q  <= !sw_q[cmss_pkg::SW_LOCK];
        end
    end

    // two-entry transmit buffer
    // [R11] drain only with clear-to-send
    wire out_ready = !busy_q && cts && ser_q.gp_mode;
    wire pop       = buf_valid && out_ready;
    wire push      = wr_en && hit_txd;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wp_q <= !wp_q;
            end
            if (pop) begin
                rp_q <= !rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            buf_mem[wp_q] <= pwdata[7:0];
        end
    end

    // [R12] frame from configuration
    function automatic logic [cmss_pkg::FRAME_W-1:0] make_frame(
        input logic [7:0] d, input cmss_pkg::cmss_ser_cfg_s c);
        logic par;
        logic [cmss_pkg::FRAME_W-1:0] f;
        par = c.seven ? ^d[6:0] : ^d;
        par = c.par_even ? par : !par;
        if (c.seven) begin
            f = c.par_en ? {3'h7, par, d[6:0], 1'b0}
                         : {4'hf, d[6:0], 1'b0};
        end else begin
            f = c.par_en ? {2'h3, par, d, 1'b0}
                         : {3'h7, d, 1'b0};
        end
        return f;
    endfunction : make_frame

    wire [3:0] frame_len = 4'h1 + (ser_q.seven ? 4'h7 : 4'h8)
                         + {3'h0, ser_q.par_en}
                         + (ser_q.two_stop ? 4'h2 : 4'h1);
    wire [cmss_pkg::FRAME_W-1:0] frame = make_frame(buf_mem[rp_q], ser_q);

    // [R19] bit timing divider
    logic [cmss_pkg::FRAME_W-1:0] shift_q;
    logic [3:0]                   bits_q;
    logic [15:0]                  div_q;
    logic [15:0]                  bdiv_q;
    logic                         txd_q;
    wire                          tick = busy_q && (div_q == 16'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q  <= 1'b0;
            shift_q <= '1;
            bits_q  <= 4'h0;
            div_q   <= 16'h0;
            bdiv_q  <= cmss_pkg::DIV_19200;
            txd_q   <= 1'b1;
        end else if (pop) begin
            busy_q  <= 1'b1;
            txd_q   <= frame[0];
            shift_q <= {1'b1, frame[cmss_pkg::FRAME_W-1:1]};
            bits_q  <= frame_len - 4'h1;
            bdiv_q  <= cmss_pkg::baud_div(ser_q.baud) - 16'h1;
            div_q   <= cmss_pkg::baud_div(ser_q.baud) - 16'h1;
        end else if (tick) begin
            div_q <= bdiv_q;
            if (bits_q == 4'h0) begin
                busy_q <= 1'b0;
            end else begin
                txd_q   <= shift_q[0];
                shift_q <= {1'b1, shift_q[cmss_pkg::FRAME_W-1:1]};
                bits_q  <= bits_q - 4'h1;
            end
        end else if (busy_q) begin
            div_q <= div_q - 16'h1;
        end
    end

    // [R10] handshake outputs held on
    logic rts_q;
    logic er_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_q <= 1'b1;
            er_q  <= 1'b1;
        end else begin
            rts_q <= 1'b1;
            er_q  <= 1'b1;
        end
    end

    assign pready        = pready_q;
    assign prdata        = prdata_q;
    assign pslverr       = pslverr_q;
    assign txd           = txd_q;
    assign rts           = rts_q;
    assign er            = er_q;
    assign run_exec      = run_q;
    assign program_mode  = program_mode_q;
    assign test_mode     = test_q;
    assign mem_init      = mem_init_q;
    assign program_mode_src_rom  = src_q;
    assign program_mode_write_en = wen_q;
    assign tool_baud_div = tool_div_q;
    assign lamp          = lamp_q;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_armed_program_mode;
        st_q == cmss_pkg::MODE_PROGRAM_MODE && test_arm_q;
    endsequence
    sequence s_run_req;
        sel_run;
    endsequence

    handshake_on_a: assert property (rts && er) // [R10]
        else $error("handshake output dropped");
    run_start_a: assert property ( // [R1]
        st_q == cmss_pkg::MODE_PROGRAM_MODE && !test_arm_q && sel_run
        |=> st_q == cmss_pkg::MODE_RUN ##1 run_exec)
        else $error("run selector did not start run");
    test_start_a: assert property ( // [R18]
        s_armed_program_mode and s_run_req |=> st_q == cmss_pkg::MODE_TEST)
        else $error("armed start did not enter test");
    program_mode_stop_a: assert property ( // [R4]
        sel_program_mode |=> st_q == cmss_pkg::MODE_PROGRAM_MODE ##1 !run_exec)
        else $error("program position did not stop");
    remote_keep_a: assert property ( // [R3]
        sel_rem && !cmd_run && !cmd_stop |=> $stable(st_q))
        else $error("centre position changed mode");
    tool_cmd_a: assert property ( // [R2]
        st_q == cmss_pkg::MODE_RUN && sel_rem && cmd_stop
        |=> st_q == cmss_pkg::MODE_PROGRAM_MODE)
        else $error("tool stop not obeyed");
    test_gate_a: assert property ( // [R5]
        $rose(test_arm_q) |-> $past(its_test))
        else $error("test armed without test position");
    sw_hold_a: assert property ( // [R9]
        sampled_q |=> $stable(sw_q) && sampled_q)
        else $error("switches resampled");
    tool_baud_a: assert property ( // [R6]
        sampled_q && sw_q[cmss_pkg::SW_BAUD]
        |=> tool_baud_div == cmss_pkg::DIV_9600)
        else $error("tool baud not forced");
    cts_gate_a: assert property ( // [R11]
        $rose(busy_q) |-> $past(cts) && $past(ser_q.gp_mode))
        else $error("transmit started without clear-to-send");
    lamp_page_a: assert property ( // [R16]
        lamp_page_sel |=> lamp == $past(input_connector_b))
        else $error("lamp page wrong");
    start_bit_a: assert property ( // [R12]
        $rose(busy_q) |-> !txd [*2])
        else $error("start bit missing");

endmodule : cmss_mode_serial

// file: cmss_field_dev.sv
// cmss_field_dev: serial field device on the far side of the com port
// assumes the frame format 8 data, odd parity, one stop bit
`timescale 1ns/100ps
module cmss_field_dev (
    // clock and line
    input  wire logic        pclk,
    input  wire logic [15:0] div,
    input  wire logic        txd,
    input  wire logic        cts_on,
    // handshake and capture
    output logic             cts,
    output logic [7:0]       rx_byte,
    output logic             rx_bad,
    output int               rx_count
);
    logic [8:0] sh;
    int         i;

    assign cts = cts_on;

    initial begin
        rx_byte = 8'h00;
        rx_bad = 1'b0;
        rx_count = 0;
    end

    // start, data lsb first, odd parity, one stop
    always begin
        @(posedge pclk);
        if (txd === 1'b0) begin
            repeat (div / 2) @(posedge pclk);
            if (txd !== 1'b0) rx_bad = 1'b1;
            for (i = 0; i < 9; i++) begin
                repeat (div) @(posedge pclk);
                sh[i] = txd;
            end
            repeat (div) @(posedge pclk);
            if (txd !== 1'b1 || (^sh) !== 1'b1) rx_bad = 1'b1;
            rx_byte = sh[7:0];
            rx_count++;
        end
    end
endmodule : cmss_field_dev

// file: cmss_mode_serial_bench.sv
// cmss_mode_serial_bench: self-checking bench of the mode/serial block
// assumes cmss_pkg and cmss_field_dev are compiled first
`timescale 1ns/100ps
module cmss_mode_serial_bench;
    logic pclk = 1'b0, presetn, psel, penable, pwrite, lamp_page_sel;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata, input_connector_a, input_connector_b;
    logic [1:0]  mode_sel, init_test_sw;
    logic [3:0]  cfg_sw;
    logic pready, pslverr, cts, txd, rts, er, run_exec, program_mode;
    logic test_mode, mem_init, program_mode_src_rom, program_mode_write_en, rbad, cts_on;
    logic [15:0] tool_baud_div;
    logic [31:0] lamp;
    logic [7:0]  rbyte;
    int failures = 0, total_checks = 0, rcnt;

    cmss_mode_serial dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .mode_sel,
        .init_test_sw, .cfg_sw, .lamp_page_sel, .input_connector_a,
        .input_connector_b, .cts, .txd, .rts, .er, .run_exec,
        .program_mode, .test_mode, .mem_init, .program_mode_src_rom,
        .program_mode_write_en, .tool_baud_div, .lamp);

    cmss_field_dev far (.pclk, .div(cmss_pkg::DIV_115K), .txd, .cts_on,
        .cts, .rx_byte(rbyte), .rx_bad(rbad), .rx_count(rcnt));

    always #4 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // waits for pready; the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        chk(pslverr, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rst(input logic [3:0] sw);
        presetn <= 1'b0;
        cfg_sw <= sw;
        tick(10);
        presetn <= 1'b1;
        tick(3);
    endtask : rst

    task automatic t_power;
        chk({rts, er, program_mode}, 3'h7);
        apb(1'b0, cmss_pkg::OFF_SER, 32'h0);
        chk(rdata[7:0], 8'h11);
        chk({program_mode_src_rom, program_mode_write_en}, 2'h0);
        chk(tool_baud_div, cmss_pkg::DIV_9600);
        cfg_sw <= 4'h2;
        tick(4);
        chk({program_mode_src_rom, program_mode_write_en, tool_baud_div}, 18'h032dc);
        rst(4'h2);
        apb(1'b1, cmss_pkg::OFF_TOOL, 32'h2);
        tick(3);
        chk(tool_baud_div, cmss_pkg::DIV_38400);
        chk({program_mode_src_rom, program_mode_write_en}, 2'h3);
        $display("power-up switches done");
    endtask : t_power

    task automatic t_mode;
        int pulses;
        mode_sel <= cmss_pkg::SEL_RUN;
        tick(4);
        chk({run_exec, program_mode}, 2'h2);
        mode_sel <= cmss_pkg::SEL_REMOTE;
        tick(4);
        chk(run_exec, 1'b1);
        apb(1'b1, cmss_pkg::OFF_CMD, 32'h2);
        tick(4);
        chk({run_exec, program_mode}, 2'h1);
        apb(1'b1, cmss_pkg::OFF_CMD, 32'h1);
        tick(4);
        chk(run_exec, 1'b1);
        mode_sel <= cmss_pkg::SEL_PROGRAM_MODE;
        tick(4);
        chk({run_exec, program_mode}, 2'h1);
        init_test_sw <= cmss_pkg::ITS_TEST;
        tick(4);
        mode_sel <= cmss_pkg::SEL_RUN;
        tick(4);
        apb(1'b0, cmss_pkg::OFF_STAT, 32'h0);
        chk({rdata[1:0], test_mode, run_exec}, 4'hb);
        mode_sel <= cmss_pkg::SEL_PROGRAM_MODE;
        init_test_sw <= cmss_pkg::ITS_CENTER;
        tick(4);
        chk(test_mode, 1'b0);
        // init position in program mode gives exactly one pulse
        init_test_sw <= cmss_pkg::ITS_INIT;
        pulses = 0;
        repeat (4) begin
            @(posedge pclk);
            if (mem_init === 1'b1) pulses++;
        end
        chk(pulses, 32'h1);
        init_test_sw <= cmss_pkg::ITS_CENTER;
        $display("mode selector done");
    endtask : t_mode

    task automatic t_serial;
        apb(1'b1, cmss_pkg::OFF_SER, 32'h94);
        apb(1'b1, cmss_pkg::OFF_TXD, 32'h5a);
        tick(200);
        chk(txd, 1'b1);
        cts_on <= 1'b1;
        for (int n = 0; n < 20000 && rcnt < 1; n++) tick(1);
        chk({rbad, rbyte}, 9'h05a);
        // link mode keeps bytes queued even with cts granted
        apb(1'b1, cmss_pkg::OFF_SER, 32'h14);
        apb(1'b1, cmss_pkg::OFF_TXD, 32'h3c);
        apb(1'b1, cmss_pkg::OFF_TXD, 32'ha5);
        apb(1'b0, cmss_pkg::OFF_STAT, 32'h0);
        chk({rdata[11], rdata[9], txd}, 3'h3);
        apb(1'b1, cmss_pkg::OFF_SER, 32'h94);
        for (int n = 0; n < 20000 && rcnt < 2; n++) tick(1);
        chk(rbyte, 8'h3c);
        for (int n = 0; n < 20000 && rcnt < 3; n++) tick(1);
        chk({rbad, rbyte, rts, er}, 11'h297);
        $display("serial port done");
    endtask : t_serial

    task automatic t_lamp;
        input_connector_a <= 32'h1234abcd;
        input_connector_b <= 32'hfedc0123;
        lamp_page_sel <= 1'b0;
        tick(3);
        chk(lamp, 32'h1234abcd);
        lamp_page_sel <= 1'b1;
        tick(3);
        chk(lamp, 32'hfedc0123);
        apb(1'b0, cmss_pkg::OFF_INB, 32'h0);
        chk(rdata, 32'hfedc0123);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= 8'h40;
        pwrite <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk(pslverr, 1'b1);
        chk(prdata, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
        $display("lamps and bus errors done");
    endtask : t_lamp

    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    initial begin
        {presetn, psel, penable, pwrite, lamp_page_sel, cts_on} = 6'h0;
        {paddr, pwdata, input_connector_a, input_connector_b} = '0;
        mode_sel = cmss_pkg::SEL_PROGRAM_MODE;
        init_test_sw = cmss_pkg::ITS_CENTER;
        cfg_sw = 4'hd;
        rst(4'hd);
        t_power;
        t_mode;
        t_serial;
        t_lamp;
        stop_test;
    end

    // three frames at 115200 take about 36k cycles; 75k is ample
    initial begin
        #600_000;
        failures++;
        stop_test;
    end
endmodule : cmss_mode_serial_bench
